//--- dv/level_interrupt_control_test.sv
// Purpose: self-checking bench of the level interrupt controller
// Assumes: sources come from the peripheral model
// Notes:   reads are checked from a queue one cycle after the strobe
module level_interrupt_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_PND = lic_pkg::ADDR_PENDING;
    localparam logic [7:0] A_MSK = lic_pkg::ADDR_MASK;
    localparam logic [7:0] A_MODE = lic_pkg::ADDR_SYS_MODE;
    localparam logic [7:0] A_PRI = lic_pkg::ADDR_PRIORITY;
    logic        clk_i = 1'b0, rst_i = 1'b1, load = 1'b0, rd_seen = 1'b0;
    logic        global_enable_instr_i = 1'b0, global_disable_instr_i = 1'b0;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, exp_q[$];
    logic [21:0] req_v = 22'h0, en_v = 22'h0, src_req_i, src_en_i;
    logic [7:0]  reg_rdata_o, intr_vector_o;
    logic        reg_hit_o, intr_req_o, intr_fast_o, ext_if_ctrl_o;
    logic [2:0]  intr_level_o;
    logic [4:0]  intr_src_o;
    int          n_mismatch = 0, total_checks = 0, cyc = 0, seed = 28;

    always #25 clk_i = ~clk_i;
    lic_level_intr_ctrl lic_level_intr_ctrl_inst (.clk_i, .rst_i,
        .global_enable_instr_i, .global_disable_instr_i, .reg_addr_i,
        .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_hit_o,
        .src_req_i, .src_en_i, .intr_req_o, .intr_level_o, .intr_src_o,
        .intr_vector_o, .intr_fast_o, .ext_if_ctrl_o);
    lic_src_model lic_src_model_inst (.clk_i, .rst_i, .load_i(load),
        .req_i(req_v), .en_i(en_v), .src_req_o(src_req_i),
        .src_en_o(src_en_i));

    task automatic report_and_stop();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one register access; a read notes its expected byte
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask
    task automatic ins(input logic en, dis);
        @(posedge clk_i);
        global_enable_instr_i <= en;
        global_disable_instr_i <= dis;
        @(posedge clk_i);
        global_enable_instr_i <= 1'b0;
        global_disable_instr_i <= 1'b0;
    endtask
    // sources are changed only while globally disabled
    task automatic srcs(input logic [21:0] r, e);
        ins(1'b0, 1'b1);
        @(posedge clk_i);
        req_v <= r;
        en_v <= e;
        load <= 1'b1;
        @(posedge clk_i);
        load <= 1'b0;
        ins(1'b1, 1'b0);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic ck(input logic q, input logic [2:0] l, input int s);
        // outputs follow a register change one edge later
        @(posedge clk_i);
        @(negedge clk_i);
        chk(8'(intr_req_o), 8'(q));
        if (q)
        begin
            chk(8'(intr_level_o), 8'(l));
            chk(8'(intr_src_o), 8'(s));
            chk(intr_vector_o, lic_pkg::SRC_VECTOR[s]);
        end
    endtask
    function automatic logic [2:0] lv(input int s);
        return 3'(s < 2 ? 0 : s < 3 ? 1 : s < 4 ? 2 : s < 8 ? 3 :
            s < 10 ? 4 : s < 14 ? 5 : s < 18 ? 6 : 7);
    endfunction

    // read data is due one cycle after its strobe
    always @(negedge clk_i)
    begin
        if (rd_seen)
            chk(reg_rdata_o, exp_q.pop_front());
        rd_seen = reg_rd_i;
    end
    // hang guard, far above the real run length
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial
    begin
        logic [21:0] e;
        logic [2:0]  w;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(0, A_MODE, 8'h00);
        acc(0, 8'h10, 8'h00);
        acc(1, A_MODE, 8'hFE);
        acc(0, A_MODE, 8'h9E);
        chk(8'(ext_if_ctrl_o), 8'h01);
        acc(1, A_MODE, 8'h00);
        ins(1'b1, 1'b0);
        acc(0, A_MODE, 8'h01);
        ins(1'b1, 1'b1);
        acc(0, A_MODE, 8'h00);
        acc(1, A_MSK, 8'hA5);
        acc(0, A_MSK, 8'hA5);
        acc(1, A_PND, 8'hFF);
        acc(0, A_PND, 8'h00);
        acc(1, A_MSK, 8'hFF);
        for (int s = 0; s < 22; s++)
        begin
            srcs(22'h1 << s, 22'h3F_FFFF);
            ck(1'b1, lv(s), s);
            acc(0, A_PND, 8'h01 << lv(s));
        end
        // level 3 contenders with random peripheral enables
        repeat (6)
        begin
            e = 22'($random(seed)) | 22'h80;
            srcs(22'hF0, e);
            ck(1'b1, 3'd3, e[4] ? 4 : e[5] ? 5 : e[6] ? 6 : 7);
        end
        srcs(22'h8, 22'h3F_FFF7);
        ck(1'b0, 3'd0, 0);
        srcs(22'h8, 22'h3F_FFFF);
        acc(1, A_MSK, 8'hFB);
        ck(1'b0, 3'd0, 0);
        acc(1, A_MSK, 8'hFF);
        acc(1, A_MODE, 8'h00);
        ck(1'b0, 3'd0, 0);
        acc(1, A_MODE, 8'h01);
        ck(1'b1, 3'd2, 3);
        ins(1'b0, 1'b1);
        @(negedge clk_i);
        chk(8'(intr_req_o), 8'h00);
        ck(1'b0, 3'd0, 0);
        // levels 0, 1, 2 and 5 all pending, every order code
        srcs(22'h40D, 22'h3F_FFFF);
        for (int p = 0; p < 16; p++)
        begin
            acc(1, A_PRI, 8'(p));
            w = p[2:0] inside {2, 3} ? 3'd2 : p[2:0] inside {4, 5} ?
                3'd5 : 3'(p[3]);
            ck(1'b1, w, w == 2 ? 3 : w == 5 ? 10 : w == 1 ? 2 : 0);
        end
        acc(1, A_PRI, 8'h00);
        for (int s = 0; s < 8; s++)
        begin
            acc(1, A_MODE, 8'(s << 2 | 3));
            @(posedge clk_i);
            @(negedge clk_i);
            chk(8'(intr_fast_o), 8'(s == 0));
        end
        // a second reset mid-run drops global and fast enable again
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(0, A_MODE, lic_pkg::SYM_RESET);
        ck(1'b0, 3'd0, 0);
        report_and_stop();
    end
endmodule // level_interrupt_control_test

//--- dv/lic_level_intr_ctrl_sva.sv
// Purpose: port assertions of the level interrupt controller
// Assumes: one clock, asynchronous active high reset
// Notes:   bound onto every controller instance
module lic_level_intr_ctrl_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        global_enable_instr_i,
    input wire logic        global_disable_instr_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_hit_o,
    input wire logic [21:0] src_req_i,
    input wire logic [21:0] src_en_i,
    input wire logic        intr_req_o,
    input wire logic [2:0]  intr_level_o,
    input wire logic [4:0]  intr_src_o,
    input wire logic [7:0]  intr_vector_o,
    input wire logic        intr_fast_o,
    input wire logic        ext_if_ctrl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // address decode seen from outside
    logic mapped;
    logic mode_wr;
    assign mapped = reg_addr_i inside {lic_pkg::ADDR_PENDING,
        lic_pkg::ADDR_MASK, lic_pkg::ADDR_SYS_MODE, lic_pkg::ADDR_PRIORITY};
    assign mode_wr = reg_wr_i && reg_addr_i == lic_pkg::ADDR_SYS_MODE;

    chk_disable_quiets: assert property (
        global_disable_instr_i |=> !intr_req_o && !intr_fast_o)
        else $error("request seen after disable");
    chk_wr_global_off: assert property (
        mode_wr && !reg_wdata_i[0] && !global_enable_instr_i
        |=> ##1 !intr_req_o) else $error("request with global off");
    chk_read_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00_00 && !reg_hit_o)
        else $error("read data without read");
    chk_hit_mapped: assert property (
        reg_rd_i |=> reg_hit_o == $past(mapped))
        else $error("hit does not match address");
    chk_ext_follows: assert property (
        mode_wr |-> ##2 ext_if_ctrl_o == $past(reg_wdata_i[7], 2))
        else $error("external control not written");
    chk_src_cause: assert property (
        intr_req_o |-> $past(|(src_req_i & src_en_i), 2))
        else $error("request without enabled source");
    chk_src_level: assert property (
        intr_req_o |-> intr_src_o >= lic_pkg::LVL_BASE[intr_level_o]
        && intr_src_o < lic_pkg::LVL_BASE[intr_level_o + 4'd1])
        else $error("source outside its level");
    chk_vector_src: assert property (
        intr_req_o |-> intr_vector_o == lic_pkg::SRC_VECTOR[intr_src_o])
        else $error("vector does not match source");
    chk_fast_needs_req: assert property (
        intr_fast_o |-> intr_req_o) else $error("fast without request");
endmodule // lic_level_intr_ctrl_sva

bind lic_level_intr_ctrl lic_level_intr_ctrl_sva lic_level_intr_ctrl_sva_inst (
    .clk_i, .rst_i, .global_enable_instr_i, .global_disable_instr_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .reg_hit_o, .src_req_i, .src_en_i, .intr_req_o, .intr_level_o,
    .intr_src_o, .intr_vector_o, .intr_fast_o, .ext_if_ctrl_o);

//--- dv/lic_src_model.sv
// Purpose: peripheral side, holds source requests and enables
// Assumes: bench loads a new pattern with a one-cycle load pulse
// Notes:   levels only; edge detection belongs to the peripherals
module lic_src_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        load_i,
    input  wire logic [21:0] req_i,
    input  wire logic [21:0] en_i,
    output logic      [21:0] src_req_o,
    output logic      [21:0] src_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // request and own enable change only on a load
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            src_req_o <= 22'h00_0000;
            src_en_o  <= 22'h00_0000;
        end
        else if (load_i)
        begin
            src_req_o <= req_i;
            src_en_o  <= en_i;
        end
    end
endmodule // lic_src_model

//--- hw/lic_level_arbiter.sv
// Purpose: pick the highest priority level among the contenders
// Assumes: candidate levels are already unmasked and globally enabled
// Notes:   groups A=0..1, B=2..4, C=5..7; lower key wins
module lic_level_arbiter (
    input  wire logic [7:0] cand_i,
    input  wire logic [7:0] prio_i,
    output logic            win_valid_o,
    output logic      [2:0] win_level_o
);

    // rank key of a level under the given priority setting
    function automatic logic [3:0] level_key(input int lvl,
                                             input logic [7:0] p);
        logic [1:0] grp;
        logic [1:0] pos;
        logic [1:0] rank;
        logic [2:0] ord;
        ord = p[lic_pkg::PRIO_ORDER_MSB:lic_pkg::PRIO_ORDER_LSB];
        if (lvl < 2)
        begin
            grp = 2'd0;
            pos = p[lic_pkg::PRIO_REV_A_BIT] ? 2'(1 - lvl) : 2'(lvl);
        end
        else if (lvl < 5)
        begin
            grp = 2'd1;
            pos = p[lic_pkg::PRIO_REV_B_BIT] ? 2'(4 - lvl) : 2'(lvl - 2);
        end
        else
        begin
            grp = 2'd2;
            pos = p[lic_pkg::PRIO_REV_C_BIT] ? 2'(7 - lvl) : 2'(lvl - 5);
        end
        // group order table: index is ord, entries give rank of A,B,C
        case (ord)
            3'd1:    rank = (grp == 2'd0) ? 2'd0 : (grp == 2'd2) ? 2'd1 : 2'd2;
            3'd2:    rank = (grp == 2'd1) ? 2'd0 : (grp == 2'd0) ? 2'd1 : 2'd2;
            3'd3:    rank = (grp == 2'd1) ? 2'd0 : (grp == 2'd2) ? 2'd1 : 2'd2;
            3'd4:    rank = (grp == 2'd2) ? 2'd0 : (grp == 2'd0) ? 2'd1 : 2'd2;
            3'd5:    rank = (grp == 2'd2) ? 2'd0 : (grp == 2'd1) ? 2'd1 : 2'd2;
            default: rank = grp;
        endcase
        return {rank, pos};
    endfunction

    // scan all levels; a strict compare keeps the first minimum
    always_comb
    begin
        logic [3:0] best;
        logic [3:0] k;
        best        = 4'hF;
        k           = 4'h0;
        win_valid_o = 1'b0;
        win_level_o = 3'd0;
        for (int l = 0; l < lic_pkg::NUM_LEVELS; l++)
        begin
            k = level_key(l, prio_i);
            if (cand_i[l] && (!win_valid_o || k < best))
            begin
                best        = k;
                win_valid_o = 1'b1;
                win_level_o = 3'(l);
            end
        end
    end

endmodule // lic_level_arbiter

//--- hw/lic_level_gather.sv
// Purpose: fold source requests into level flags and in-level winners
// Assumes: requests and enables are levels, synchronous to clk_i
// Notes:   purely combinational; the caller registers the results
module lic_level_gather (
    input  wire logic [21:0] src_req_i,
    input  wire logic [21:0] src_en_i,
    output logic      [7:0]  lvl_active_o,
    output logic      [39:0] lvl_win_o
);

    // first qualified source of a level, lowest index wins
    function automatic logic [4:0] first_src(input logic [21:0] q,
                                             input int lo,
                                             input int hi);
        logic [4:0] w;
        w = 5'h00;
        for (int s = hi - 1; s >= lo; s--)
        begin
            if (q[s])
            begin
                w = 5'(s);
            end
        end
        return w;
    endfunction

    logic [21:0] qual;

    // a request counts only while its peripheral enables it
    assign qual = src_req_i & src_en_i;

    // per level or-reduction and fixed in-level order
    always_comb
    begin
        lvl_active_o = '0;
        lvl_win_o    = '0;
        for (int l = 0; l < lic_pkg::NUM_LEVELS; l++)
        begin
            for (int s = int'(lic_pkg::LVL_BASE[l]);
                 s < int'(lic_pkg::LVL_BASE[l+1]); s++)
            begin
                lvl_active_o[l] = lvl_active_o[l] | qual[s];
            end
            lvl_win_o[l*5 +: 5] = first_src(qual,
                int'(lic_pkg::LVL_BASE[l]),
                int'(lic_pkg::LVL_BASE[l+1]));
        end
    end

endmodule // lic_level_gather

//--- hw/lic_level_intr_ctrl.sv
// Purpose: system level interrupt control: global enable, level mask,
//          level priority, level pending and system mode register
// Assumes: core drives a byte-wide register port and instruction
//          strobes, all synchronous to clk_i
// Notes:   the core reads request, level and vector two cycles after
//          the sources settle; servicing itself belongs to the core
//          mask, priority and fast select reset to zero by choice

module lic_level_intr_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // instruction strobes from the core
    input  wire logic        global_enable_instr_i,
    input  wire logic        global_disable_instr_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_hit_o,
    // sources and their peripheral enables
    input  wire logic [21:0] src_req_i,
    input  wire logic [21:0] src_en_i,
    // to the core
    output logic             intr_req_o,
    output logic      [2:0]  intr_level_o,
    output logic      [4:0]  intr_src_o,
    output logic      [7:0]  intr_vector_o,
    output logic             intr_fast_o,
    output logic             ext_if_ctrl_o
);

    // register file state
    logic [7:0]  sym_q,   sym_d;
    logic [7:0]  mask_q,  mask_d;
    logic [7:0]  prio_q,  prio_d;
    logic [7:0]  pend_q,  pend_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        hit_q,   hit_d;
    // request path state, one winner per cycle
    logic        req_q,   req_d;
    logic [2:0]  lvl_q,   lvl_d;
    logic [4:0]  src_q,   src_d;
    logic [7:0]  vec_q,   vec_d;
    logic        fast_q,  fast_d;

    // links between the gather, arbiter and output stages
    logic [7:0]  lvl_active;
    logic [39:0] lvl_win;
    logic [7:0]  cand;
    logic        win_valid;
    logic [2:0]  win_level;

    // true when a write targets the given address
    function automatic logic wr_hit(input logic       wr,
                                    input logic [7:0] a,
                                    input logic [7:0] target);
        return wr && (a == target);
    endfunction

    // true when the fast path is armed for the given level
    function automatic logic fast_hit(input logic [7:0] mode,
                                      input logic [2:0] lvl);
        return mode[lic_pkg::SYM_FAST_EN_BIT]
               && (lvl == mode[lic_pkg::SYM_FAST_SEL_MSB:
                               lic_pkg::SYM_FAST_SEL_LSB]);
    endfunction

    // source to level folding, fixed map held in the package
    lic_level_gather lic_level_gather_inst (
        .src_req_i    (src_req_i),
        .src_en_i     (src_en_i),
        .lvl_active_o (lvl_active),
        .lvl_win_o    (lvl_win)
    );

    // only unmasked levels contend, and only while globally enabled
    assign cand = (sym_q[lic_pkg::SYM_GLOBAL_EN_BIT] ? pend_q : 8'h00_00)
                  & mask_q;

    // priority among the unmasked pending levels
    lic_level_arbiter lic_level_arbiter_inst (
        .cand_i      (cand),
        .prio_i      (prio_q),
        .win_valid_o (win_valid),
        .win_level_o (win_level)
    );

    // mode register: direct writes first, then the instruction strobes
    always_comb
    begin
        sym_d = sym_q;
        if (wr_hit(reg_wr_i, reg_addr_i, lic_pkg::ADDR_SYS_MODE))
        begin
            // reserved bits stay zero
            sym_d = reg_wdata_i & lic_pkg::SYM_WRITE_MASK;
        end
        // instruction beats a same-cycle write on bit 0 only
        if (global_disable_instr_i)
        begin
            sym_d[lic_pkg::SYM_GLOBAL_EN_BIT] = 1'b0;
        end
        else if (global_enable_instr_i)
        begin
            sym_d[lic_pkg::SYM_GLOBAL_EN_BIT] = 1'b1;
        end
    end

    // reset drops global and fast enable; select reset is our choice
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sym_q <= lic_pkg::SYM_RESET;
        end
        else
        begin
            sym_q <= sym_d;
        end
    end

    // level mask: plain byte register, bit n gates level n
    always_comb
    begin
        mask_d = mask_q;
        if (wr_hit(reg_wr_i, reg_addr_i, lic_pkg::ADDR_MASK))
        begin
            mask_d = reg_wdata_i;
        end
    end

    // zero after reset keeps every level masked until software writes
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mask_q <= lic_pkg::MASK_RESET;
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    // level priority: stored whole, bits 7:6 unused by the arbiter
    always_comb
    begin
        prio_d = prio_q;
        if (wr_hit(reg_wr_i, reg_addr_i, lic_pkg::ADDR_PRIORITY))
        begin
            prio_d = reg_wdata_i;
        end
    end

    // zero selects the plain group order after reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prio_q <= lic_pkg::PRIO_RESET;
        end
        else
        begin
            prio_q <= prio_d;
        end
    end

    // pending flags follow the sources; writes cannot reach them
    always_comb
    begin
        pend_d = lvl_active;
    end

    // a plain copy; the peripherals keep their own latched flags
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pend_q <= 8'h00_00;
        end
        else
        begin
            pend_q <= pend_d;
        end
    end

    // request flags; the disable strobe also drops one on its way out
    always_comb
    begin
        req_d  = win_valid && !global_disable_instr_i;
        // fast path only for the one selected level
        fast_d = win_valid && !global_disable_instr_i
                 && fast_hit(sym_q, win_level);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            req_q  <= 1'b0;
            fast_q <= 1'b0;
        end
        else
        begin
            req_q  <= req_d;
            fast_q <= fast_d;
        end
    end

    // winner payload; zero source and vector while nothing contends
    always_comb
    begin
        lvl_d = win_level;
        src_d = lvl_win[win_level*5 +: 5];
        vec_d = lic_pkg::SRC_VECTOR[src_d];
        if (!win_valid)
        begin
            src_d = 5'h00;
            vec_d = 8'h00_00;
        end
    end

    // payload moves in step with the flags, so level, source and
    // vector always describe the same winner
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lvl_q <= 3'd0;
            src_q <= 5'h00;
            vec_q <= 8'h00_00;
        end
        else
        begin
            lvl_q <= lvl_d;
            src_q <= src_d;
            vec_q <= vec_d;
        end
    end

    // registered read port; unmapped addresses read zero, no hit
    always_comb
    begin
        rdata_d = 8'h00_00;
        hit_d   = 1'b0;
        if (reg_rd_i)
        begin
            hit_d = 1'b1;
            case (reg_addr_i)
                lic_pkg::ADDR_SYS_MODE: rdata_d = sym_q;
                lic_pkg::ADDR_MASK:     rdata_d = mask_q;
                lic_pkg::ADDR_PRIORITY: rdata_d = prio_q;
                lic_pkg::ADDR_PENDING:  rdata_d = pend_q;
                default:                hit_d   = 1'b0;
            endcase
        end
    end

    // registered so the core samples a steady byte the next cycle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 8'h00_00;
            hit_q   <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
        end
    end

    // register port outputs, straight from their flops
    assign reg_rdata_o   = rdata_q;
    assign reg_hit_o     = hit_q;

    // core side outputs, all registered
    assign intr_req_o    = req_q;
    assign intr_level_o  = lvl_q;
    assign intr_src_o    = src_q;
    assign intr_vector_o = vec_q;
    assign intr_fast_o   = fast_q;
    assign ext_if_ctrl_o = sym_q[lic_pkg::SYM_EXT_IF_BIT];

endmodule // lic_level_intr_ctrl

//--- hw/lic_pkg.sv
// Purpose: shared constants of the level interrupt controller
// Assumes: one core clock, register port driven by the core
// Notes:   source numbering follows the vector order, lowest first
package lic_pkg;

    localparam int NUM_LEVELS = 8;
    localparam int NUM_SRCS   = 22;
    localparam int SRC_IDX_W  = 5;

    // register file addresses
    localparam logic [7:0] ADDR_PENDING  = 8'h00_DC;
    localparam logic [7:0] ADDR_MASK     = 8'h00_DD;
    localparam logic [7:0] ADDR_SYS_MODE = 8'h00_DE;
    localparam logic [7:0] ADDR_PRIORITY = 8'h00_FF;

    // system mode fields
    localparam int SYM_GLOBAL_EN_BIT = 0;
    localparam int SYM_FAST_EN_BIT   = 1;
    localparam int SYM_FAST_SEL_LSB  = 2;
    localparam int SYM_FAST_SEL_MSB  = 4;
    localparam int SYM_EXT_IF_BIT    = 7;
    // bits 6:5 are reserved and read as zero
    localparam logic [7:0] SYM_WRITE_MASK = 8'h00_9F;

    // reset values; mask and fast select are formally undefined
    localparam logic [7:0] SYM_RESET  = 8'h00_00;
    localparam logic [7:0] MASK_RESET = 8'h00_00;
    localparam logic [7:0] PRIO_RESET = 8'h00_00;

    // priority register fields
    localparam int PRIO_ORDER_LSB = 0;
    localparam int PRIO_ORDER_MSB = 2;
    localparam int PRIO_REV_A_BIT = 3;
    localparam int PRIO_REV_B_BIT = 4;
    localparam int PRIO_REV_C_BIT = 5;

    // first source index of each level, plus the end marker
    localparam logic [8:0][4:0] LVL_BASE = {
        5'h16, 5'h12, 5'h0E, 5'h0A, 5'h08, 5'h04, 5'h03, 5'h02, 5'h00
    };

    // low byte of each source's vector address
    localparam logic [21:0][7:0] SRC_VECTOR = {
        8'h00_FE, 8'h00_FC, 8'h00_FA, 8'h00_F8,
        8'h00_F6, 8'h00_F4, 8'h00_F2, 8'h00_F0,
        8'h00_EE, 8'h00_EC, 8'h00_EA, 8'h00_E8,
        8'h00_E6, 8'h00_E4,
        8'h00_DE, 8'h00_DC, 8'h00_DA, 8'h00_D8,
        8'h00_D4, 8'h00_D2, 8'h00_D0, 8'h00_CE
    };

endpackage : lic_pkg
